//--- inc/resampler_pkg.sv
// shared constants for the channel combiner and resampler
// assumes one chip clock and an AHB-Lite register port
package resampler_pkg;
    localparam int NUM_CH = 4;
    localparam int SAMPLE_W = 24;
    localparam int SUM_W = 25;
    localparam int COEF_W = 12;
    localparam int COEF_ADDR_W = 12;
    localparam int PROD_W = SUM_W + COEF_W;
    localparam int ACC_W = 44;
    localparam int BUF_DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam int RATIO_W = 32;
    localparam int FRAC_W = 26;
    localparam int PHASE_W = 7;
    localparam int IDX_W = 9;
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] REG_CHAN_COUNT_IDX = 9'h010;
    localparam logic [IDX_W-1:0] REG_FILTER_IDX = 9'h011;
    localparam logic [IDX_W-1:0] REG_SUM_ROUTE_IDX = 9'h015;
    localparam logic [IDX_W-1:0] REG_RATIO_MAP_IDX = 9'h017;
    localparam logic [IDX_W-1:0] REG_CHAN_CTRL_IDX = 9'h020;
    localparam logic [IDX_W-1:0] REG_STATUS_IDX = 9'h028;
    localparam logic [IDX_W-1:0] REG_RATIO_IDX = 9'h050;
    localparam int RATIO_STRIDE = 4;
    // field positions
    localparam int INTERP_LSB = 8;
    localparam int ROUTE_LSB = 8;
    localparam int PATTERN_LSB = 16;
    localparam int STATUS_SLOT = 8;
    // reset values
    localparam logic [1:0] CHAN_COUNT_RST = 2'h2;
    localparam logic [5:0] NMULT_RST = 6'h07;
    localparam logic [2:0] INTERP_LOG2_RST = 3'h2;
    localparam logic [RATIO_W-1:0] RATIO_RST = 32'h04000000;
    // mixer phase offsets taken as quarter turns
    localparam logic [15:0] PHASE_PLUS90 = 16'h4000;
    localparam logic [15:0] PHASE_MINUS90 = 16'hC000;
    localparam logic [15:0] PHASE_HALF = 16'h8000;
    localparam logic [1:0] SIGN_LAST_STEP = 2'h3;
    localparam logic [6:0] SEG_FULL_ALL = 7'h40;
    localparam logic [PTR_W-1:0] PTR_MASK_ALL = 6'h3F;
    typedef enum logic [1:0] {ENG_SCAN, ENG_MAC, ENG_DONE} eng_state_type;
endpackage

//--- rtl/channel_conditioner.sv
// quarter-turn phase offset and alternating sign pattern for one channel
// assumes samples arrive from upstream filter logic on the same clock
`timescale 1ns/1ns
module channel_conditioner import resampler_pkg::*; (
    input wire logic signed [SAMPLE_W-1:0] i_in,
    input wire logic signed [SAMPLE_W-1:0] q_in,
    input wire logic [15:0] phase_in,
    input wire logic [3:0] pattern_in,
    input wire logic [1:0] step_in,
    output logic signed [SAMPLE_W-1:0] i_out,
    output logic signed [SAMPLE_W-1:0] q_out
);
    logic signed [SAMPLE_W-1:0] rot_i;
    logic signed [SAMPLE_W-1:0] rot_q;
    logic neg;

    always_comb begin
        // other offsets are left to the upstream mixer
        case (phase_in)
            PHASE_PLUS90: begin
                rot_i = -q_in;
                rot_q = i_in;
            end
            PHASE_MINUS90: begin
                rot_i = q_in;
                rot_q = -i_in;
            end
            PHASE_HALF: begin
                rot_i = -i_in;
                rot_q = -q_in;
            end
            default: begin
                rot_i = i_in;
                rot_q = q_in;
            end
        endcase
        // msb is the first sample, a set bit negates
        neg = pattern_in[SIGN_LAST_STEP - step_in];
        i_out = neg ? -rot_i : rot_i;
        q_out = neg ? -rot_q : rot_q;
    end
endmodule

//--- rtl/rate_accumulator.sv
// fixed-point position step and nearest interpolation phase
// assumes the ratio carries 26 fraction bits
`timescale 1ns/1ns
module rate_accumulator import resampler_pkg::*; (
    input wire logic [FRAC_W-1:0] frac_in,
    input wire logic [RATIO_W-1:0] ratio_in,
    input wire logic [2:0] interp_log2_in,
    output logic [FRAC_W-1:0] frac_out,
    output logic [CNT_W-1:0] consume_out,
    output logic [PHASE_W-1:0] phase_out
);
    logic [RATIO_W:0] sum;
    logic [FRAC_W:0] rnd;
    logic [FRAC_W:0] rnd_sh;

    always_comb begin
        sum = {1'b0, ratio_in} + {7'h00, frac_in};
        frac_out = sum[FRAC_W-1:0];
        consume_out = sum[RATIO_W:FRAC_W];
        // half a phase step added, so truncation picks the nearest phase
        rnd = {1'b0, frac_in} + ({1'b0, 26'h2000000} >> interp_log2_in);
        rnd_sh = rnd >> (5'(FRAC_W) - {2'h0, interp_log2_in});
        // a phase equal to the factor means the next input with phase zero
        phase_out = rnd_sh[PHASE_W-1:0];
    end
endmodule

//--- rtl/channel_combine_resampler.sv
// channel combiner, segmented input buffer and polyphase resampler
// assumes upstream channels share this clock and coef memory answers at once
// Notes on behaviour
// - phase offset 0x4000 rotates by +90 degrees, 0xC000 by -90 degrees.
// - sum bit 0 adds A into B, sum bit 2 adds C into D, in I and Q alike.
// - each resampler channel is filtered and rate-changed on its own.
// - rate is factor over step; fractional steps use the nearest phase.
// - 24-bit inputs of four channels are summed in pairs and routed into 1, 2 or 4 channels.
// - input buffer is both decoupling FIFO and filter delay line.
// - 64-word buffer splits into four 16, two 32 or one 64 word segments; count code 3 here gives four 8 word segments.
// - zero-stuff by the factor, filter, keep every step-th result.
// - 32-bit ratio words hold 2^26 times input over output rate.
// - four ratio words stored; a map picks one per channel.
// - pattern 5 gives +,-,+,-; pattern 10 gives -,+,-,+.
// - a set sum bit adds that channel into its neighbour first.
// - route fields send each combined group to one resampler channel.
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
module channel_combine_resampler import resampler_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic [NUM_CH*SAMPLE_W-1:0] ch_i_in,
    input wire logic [NUM_CH*SAMPLE_W-1:0] ch_q_in,
    input wire logic ch_valid_in,
    output logic ch_ready_out,
    output logic [COEF_ADDR_W-1:0] coef_addr_out,
    input wire logic signed [COEF_W-1:0] coef_in,
    output logic signed [ACC_W-1:0] res_i_out,
    output logic signed [ACC_W-1:0] res_q_out,
    output logic [1:0] res_chan_out,
    output logic res_valid_out,
    input wire logic res_ready_in
);
    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    logic dph_wr_r;
    logic dph_rd_r;
    logic rd_done_r;
    logic dph_ok_r;
    logic [IDX_W-1:0] dph_idx_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_mux;
    logic addr_take;
    logic wr_en;

    logic [1:0] count_code_r;
    logic [5:0] nmult_r;
    logic [2:0] interp_log2_r;
    logic [1:0] sum_sel_r;
    logic [7:0] route_r;
    logic [7:0] ratio_map_r;
    logic [15:0] phase_r [NUM_CH];
    logic [3:0] pattern_r [NUM_CH];
    logic [RATIO_W-1:0] ratio_r [NUM_CH];
    logic [CNT_W-1:0] cnt_r [NUM_CH];

    // hsize is not checked: only whole words are expected
    assign addr_take = hsel_in & hready_in & htrans_in[1];
    assign wr_en = dph_wr_r & dph_ok_r;
    // reads take one wait cycle so hrdata comes from a flop
    assign hreadyout_out = ~(dph_rd_r & ~rd_done_r);
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_r;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dph_wr_r <= 1'b0;
            dph_rd_r <= 1'b0;
            dph_ok_r <= 1'b0;
            dph_idx_r <= '0;
        end else if (hreadyout_out) begin
            dph_wr_r <= addr_take & hwrite_in;
            dph_rd_r <= addr_take & ~hwrite_in;
            if (addr_take) begin
                dph_idx_r <= haddr_in[IDX_W+1:2];
                dph_ok_r <= (haddr_in[31:IDX_W+2] == '0);
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_done_r <= 1'b0;
            hrdata_r <= '0;
        end else begin
            rd_done_r <= dph_rd_r & ~rd_done_r;
            if (dph_rd_r & ~rd_done_r) begin
                hrdata_r <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = '0;
        if (dph_ok_r) begin
            case (dph_idx_r)
                REG_CHAN_COUNT_IDX: rd_mux = {30'h0, count_code_r};
                REG_FILTER_IDX: rd_mux = {21'h0, interp_log2_r, 2'h0, nmult_r};
                REG_SUM_ROUTE_IDX: begin
                    rd_mux = {16'h0, route_r, 5'h0, sum_sel_r[1], 1'b0, sum_sel_r[0]};
                end
                REG_RATIO_MAP_IDX: rd_mux = {24'h0, ratio_map_r};
                default: rd_mux = '0;
            endcase
            for (int k = 0; k < NUM_CH; k++) begin
                if (dph_idx_r == REG_CHAN_CTRL_IDX + IDX_W'(k)) begin
                    rd_mux = {12'h0, pattern_r[k], phase_r[k]};
                end
                if (dph_idx_r == REG_RATIO_IDX + IDX_W'(k * RATIO_STRIDE)) begin
                    rd_mux = ratio_r[k];
                end
                if (dph_idx_r == REG_STATUS_IDX) begin
                    rd_mux[k*STATUS_SLOT +: CNT_W] = cnt_r[k];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_code_r <= CHAN_COUNT_RST;
            nmult_r <= NMULT_RST;
            interp_log2_r <= INTERP_LOG2_RST;
            sum_sel_r <= '0;
            route_r <= '0;
            ratio_map_r <= '0;
        end else if (wr_en) begin
            case (dph_idx_r)
                REG_CHAN_COUNT_IDX: count_code_r <= hwdata_in[1:0];
                REG_FILTER_IDX: begin
                    nmult_r <= hwdata_in[5:0];
                    interp_log2_r <= hwdata_in[INTERP_LSB +: 3];
                end
                REG_SUM_ROUTE_IDX: begin
                    sum_sel_r <= {hwdata_in[2], hwdata_in[0]};
                    route_r <= hwdata_in[ROUTE_LSB +: 8];
                end
                REG_RATIO_MAP_IDX: ratio_map_r <= hwdata_in[7:0];
                default: ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_chan_regs
            always_ff @(posedge clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    phase_r[g] <= '0;
                    pattern_r[g] <= '0;
                    ratio_r[g] <= RATIO_RST;
                end else if (wr_en) begin
                    if (dph_idx_r == REG_CHAN_CTRL_IDX + IDX_W'(g)) begin
                        phase_r[g] <= hwdata_in[15:0];
                        pattern_r[g] <= hwdata_in[PATTERN_LSB +: 4];
                    end
                    if (dph_idx_r == REG_RATIO_IDX + IDX_W'(g * RATIO_STRIDE)) begin
                        ratio_r[g] <= hwdata_in;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // channel combining
    // ------------------------------------------------------------
    logic signed [SAMPLE_W-1:0] cond_i [NUM_CH];
    logic signed [SAMPLE_W-1:0] cond_q [NUM_CH];
    logic signed [SUM_W-1:0] comb_i [NUM_CH];
    logic signed [SUM_W-1:0] comb_q [NUM_CH];
    logic [NUM_CH-1:0] lane_wr;
    logic [1:0] lane_seg [NUM_CH];
    logic [NUM_CH-1:0] seg_wr;
    logic signed [SUM_W-1:0] seg_wi [NUM_CH];
    logic signed [SUM_W-1:0] seg_wq [NUM_CH];
    logic [1:0] seg_mask;
    logic [CNT_W-1:0] seg_full;
    logic [PTR_W-1:0] ptr_mask;
    logic [1:0] step_r;
    logic take;

    generate
        for (g = 0; g < NUM_CH; g++) begin : g_cond
            channel_conditioner u_cond (
                .i_in(ch_i_in[g*SAMPLE_W +: SAMPLE_W]),
                .q_in(ch_q_in[g*SAMPLE_W +: SAMPLE_W]),
                .phase_in(phase_r[g]),
                .pattern_in(pattern_r[g]),
                .step_in(step_r),
                .i_out(cond_i[g]),
                .q_out(cond_q[g])
            );
        end
    endgenerate

    assign seg_mask = (count_code_r == 2'h0) ? 2'h0 : (count_code_r == 2'h1) ? 2'h1 : 2'h3;
    assign seg_full = SEG_FULL_ALL >> count_code_r;
    assign ptr_mask = PTR_MASK_ALL >> count_code_r;

    function automatic logic [PTR_W-1:0] buf_addr(input logic [1:0] s,
                                                  input logic [PTR_W-1:0] p,
                                                  input logic [1:0] c,
                                                  input logic [PTR_W-1:0] m);
        logic [7:0] base;
        base = {6'h00, s} << (3'(PTR_W) - {1'b0, c});
        return base[PTR_W-1:0] | (p & m);
    endfunction

    always_comb begin
        ch_ready_out = 1'b1;
        seg_wr = '0;
        for (int k = 0; k < NUM_CH; k++) begin
            comb_i[k] = SUM_W'(cond_i[k]);
            comb_q[k] = SUM_W'(cond_q[k]);
            // a summed lane is folded into the next one and not written
            lane_wr[k] = !((k % 2 == 0) && sum_sel_r[k/2]);
            if ((k % 2 == 1) && sum_sel_r[k/2]) begin
                comb_i[k] = comb_i[k] + SUM_W'(cond_i[k-1]);
                comb_q[k] = comb_q[k] + SUM_W'(cond_q[k-1]);
            end
            lane_seg[k] = route_r[2*k +: 2] & seg_mask;
            seg_wi[k] = '0;
            seg_wq[k] = '0;
        end
        for (int k = 0; k < NUM_CH; k++) begin
            // lanes routed alike: the higher lane wins
            if (lane_wr[k]) begin
                seg_wr[lane_seg[k]] = 1'b1;
                seg_wi[lane_seg[k]] = comb_i[k];
                seg_wq[lane_seg[k]] = comb_q[k];
                if (cnt_r[lane_seg[k]] >= seg_full) begin
                    ch_ready_out = 1'b0;
                end
            end
        end
    end

    assign take = ch_valid_in & ch_ready_out;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            step_r <= '0;
        end else if (take) begin
            step_r <= step_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // input buffer: fifo and delay line
    // ------------------------------------------------------------
    logic signed [SUM_W-1:0] buf_i_r [BUF_DEPTH];
    logic signed [SUM_W-1:0] buf_q_r [BUF_DEPTH];
    logic [PTR_W-1:0] wr_ptr_r [NUM_CH];
    logic [PTR_W-1:0] rd_ptr_r [NUM_CH];
    logic eng_pop;
    eng_state_type eng_r;
    logic [1:0] ch_r;

    always_ff @(posedge clk_in) begin
        for (int s = 0; s < NUM_CH; s++) begin
            if (take && seg_wr[s]) begin
                buf_i_r[buf_addr(2'(s), wr_ptr_r[s], count_code_r, ptr_mask)] <= seg_wi[s];
                buf_q_r[buf_addr(2'(s), wr_ptr_r[s], count_code_r, ptr_mask)] <= seg_wq[s];
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int s = 0; s < NUM_CH; s++) begin
                wr_ptr_r[s] <= '0;
                rd_ptr_r[s] <= '0;
                cnt_r[s] <= '0;
            end
        end else begin
            for (int s = 0; s < NUM_CH; s++) begin
                // decouples channel pace from resampler pace
                if (take && seg_wr[s]) begin
                    wr_ptr_r[s] <= wr_ptr_r[s] + 6'h01;
                end
                if (eng_pop && ch_r == 2'(s)) begin
                    rd_ptr_r[s] <= rd_ptr_r[s] + 6'h01;
                end
                cnt_r[s] <= cnt_r[s] + CNT_W'(take && seg_wr[s])
                            - CNT_W'(eng_pop && ch_r == 2'(s));
            end
        end
    end

    // ------------------------------------------------------------
    // interpolation engine
    // ------------------------------------------------------------
    logic [5:0] m_r;
    logic [PHASE_W-1:0] eng_phase_r;
    logic signed [ACC_W-1:0] acc_i_r;
    logic signed [ACC_W-1:0] acc_q_r;
    logic [FRAC_W-1:0] frac_r [NUM_CH];
    logic [CNT_W-1:0] skip_r [NUM_CH];
    logic [FRAC_W-1:0] ra_frac;
    logic [CNT_W-1:0] ra_consume;
    logic [PHASE_W-1:0] ra_phase;
    logic [PTR_W-1:0] tap_addr;
    logic [COEF_ADDR_W:0] coef_idx;
    logic [COEF_ADDR_W:0] resample_filter_length;
    logic signed [COEF_W-1:0] coef_eff;
    logic signed [PROD_W-1:0] prod_i;
    logic signed [PROD_W-1:0] prod_q;
    logic [1:0] ch_next;

    rate_accumulator u_rate (
        .frac_in(frac_r[ch_r]),
        .ratio_in(ratio_r[ratio_map_r[2*ch_r +: 2]]),
        .interp_log2_in(interp_log2_r),
        .frac_out(ra_frac),
        .consume_out(ra_consume),
        .phase_out(ra_phase)
    );

    assign ch_next = (ch_r + 2'h1) & seg_mask;
    assign eng_pop = (eng_r == ENG_SCAN) && (skip_r[ch_r] != '0) && (cnt_r[ch_r] != '0);

    always_comb begin
        // newest sample pairs with the lowest coefficient
        tap_addr = buf_addr(ch_r, rd_ptr_r[ch_r] + nmult_r - 6'h01 - m_r,
                            count_code_r, ptr_mask);
        coef_idx = ({7'h00, m_r} << interp_log2_r) + {6'h00, eng_phase_r};
        resample_filter_length = {7'h00, nmult_r} << interp_log2_r;
        // the stuffed zeros are skipped, only real samples meet a coefficient
        coef_eff = (coef_idx < resample_filter_length) ? coef_in : '0;
        prod_i = PROD_W'(buf_i_r[tap_addr]) * PROD_W'(coef_eff);
        prod_q = PROD_W'(buf_q_r[tap_addr]) * PROD_W'(coef_eff);
    end

    assign coef_addr_out = coef_idx[COEF_ADDR_W-1:0];
    assign res_valid_out = (eng_r == ENG_DONE);

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            eng_r <= ENG_SCAN;
            ch_r <= '0;
            m_r <= '0;
            eng_phase_r <= '0;
            acc_i_r <= '0;
            acc_q_r <= '0;
            res_chan_out <= '0;
            for (int s = 0; s < NUM_CH; s++) begin
                frac_r[s] <= '0;
                skip_r[s] <= '0;
            end
        end else begin
            case (eng_r)
                ENG_SCAN: begin
                    if (skip_r[ch_r] != '0) begin
                        if (eng_pop) begin
                            skip_r[ch_r] <= skip_r[ch_r] - 7'h01;
                        end else begin
                            ch_r <= ch_next;
                        end
                    end else if (nmult_r != '0 && cnt_r[ch_r] >= {1'b0, nmult_r}) begin
                        eng_r <= ENG_MAC;
                        m_r <= '0;
                        eng_phase_r <= ra_phase;
                        acc_i_r <= '0;
                        acc_q_r <= '0;
                    end else begin
                        ch_r <= ch_next;
                    end
                end
                ENG_MAC: begin
                    acc_i_r <= acc_i_r + ACC_W'(prod_i);
                    acc_q_r <= acc_q_r + ACC_W'(prod_q);
                    m_r <= m_r + 6'h01;
                    if (m_r == nmult_r - 6'h01) begin
                        eng_r <= ENG_DONE;
                        res_chan_out <= ch_r;
                        // keep one output per step of the ratio
                        frac_r[ch_r] <= ra_frac;
                        skip_r[ch_r] <= ra_consume;
                    end
                end
                ENG_DONE: begin
                    if (res_ready_in) begin
                        eng_r <= ENG_SCAN;
                        ch_r <= ch_next;
                    end
                end
                default: eng_r <= ENG_SCAN;
            endcase
        end
    end

    assign res_i_out = acc_i_r;
    assign res_q_out = acc_q_r;
endmodule

//--- testbench/ccr_asserts.sv
// checker for bus timing and result hand-off of the resampler
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
module ccr_asserts import resampler_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic [31:0] hrdata_out,
    input wire logic signed [ACC_W-1:0] res_i_out,
    input wire logic signed [ACC_W-1:0] res_q_out,
    input wire logic [1:0] res_chan_out,
    input wire logic res_valid_out,
    input wire logic res_ready_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic acc;
    assign acc = hsel_in & hready_in & htrans_in[1] & hreadyout_out;
    chk_resp_okay: assert property (hresp_out == 1'b0)
        else $error("bus response not okay");
    chk_read_wait: assert property (acc && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (acc && hwrite_in |=> hreadyout_out)
        else $error("write stalled");
    chk_wait_cause: assert property (!hreadyout_out |-> $past(acc && !hwrite_in))
        else $error("wait state without read");
    chk_rdata_hold: assert property ($changed(hrdata_out) |-> $past(!hreadyout_out))
        else $error("read data changed outside a read");
    chk_unmapped_zero: assert property (acc && !hwrite_in && haddr_in[31:11] != 21'h0
        |=> ##1 hrdata_out == 32'h0)
        else $error("unmapped read not zero");
    chk_res_hold: assert property (res_valid_out && !res_ready_in |=>
        res_valid_out && $stable(res_i_out) && $stable(res_q_out) && $stable(res_chan_out))
        else $error("result dropped while stalled");
    // a new sum takes one scan cycle plus one per tap, so six idle cycles need five taps or more
    chk_result_gap: assert property (res_valid_out && res_ready_in |=> !res_valid_out [*6])
        else $error("result too soon after previous");
endmodule
bind channel_combine_resampler ccr_asserts chk (.clk_in, .reset_n_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hready_in, .hreadyout_out, .hresp_out, .hrdata_out, .res_i_out,
    .res_q_out, .res_chan_out, .res_valid_out, .res_ready_in);

//--- testbench/upstream_channels.sv
// upstream channel model: four lanes of I and Q with valid and ready
// assumes lane values come from the bench and hold while enabled
`timescale 1ns/1ns
module upstream_channels import resampler_pkg::*; (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic en_in,
    input wire logic slow_in,
    input wire logic [NUM_CH*SAMPLE_W-1:0] lane_i_in,
    input wire logic [NUM_CH*SAMPLE_W-1:0] lane_q_in,
    input wire logic ch_ready_in,
    output logic [NUM_CH*SAMPLE_W-1:0] ch_i_out,
    output logic [NUM_CH*SAMPLE_W-1:0] ch_q_out,
    output logic ch_valid_out
);
    logic gap_r;
    logic go;
    assign go = en_in && (!slow_in || gap_r);
    // frame held until taken; idle lanes toggle so stale data never matches
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gap_r <= 1'b0;
            ch_valid_out <= 1'b0;
            ch_i_out <= '0;
            ch_q_out <= '0;
        end else if (!ch_valid_out || ch_ready_in) begin
            gap_r <= ~gap_r;
            ch_valid_out <= go;
            ch_i_out <= go ? lane_i_in : ~ch_i_out;
            ch_q_out <= go ? lane_q_in : ~ch_q_out;
        end
    end
endmodule

//--- testbench/channel_combine_resampler_tb.sv
// bench: register access over the bus, then a combined stream
// assumes coefficient memory answers at once; taps at multiples of four are one here
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module channel_combine_resampler_tb import resampler_pkg::*;;
    logic clk_in = 1'b0, reset_n_in = 1'b0, hsel = 1'b0, hwrite = 1'b0, hresp, hreadyout;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0, res_chan;
    logic [2:0] hsize = 3'h2;
    logic [NUM_CH*SAMPLE_W-1:0] ci, cq, lane_i, lane_q;
    logic cv, cr, res_valid, res_ready = 1'b0, en = 1'b0, slow = 1'b0;
    logic [COEF_ADDR_W-1:0] coef_addr;
    logic signed [COEF_W-1:0] coef;
    logic signed [ACC_W-1:0] res_i, res_q, ei[4], eq[4];
    logic signed [SAMPLE_W-1:0] li[4] = '{24'sh000010, 24'sh000020, 24'sh000100, -24'sh000100};
    logic signed [SAMPLE_W-1:0] lq[4] = '{24'sh000003, -24'sh000001, 24'sh000005, 24'sh000007};
    int fails = 0, checks_done = 0, n;
    always #2 clk_in = ~clk_in;
    assign lane_i = {li[3], li[2], li[1], li[0]};
    assign lane_q = {lq[3], lq[2], lq[1], lq[0]};
    // phase zero only meets taps at multiples of four: any other index spoils the sum
    assign coef = (coef_addr[1:0] == 2'h0) ? 12'sh001 : 12'sh7FF;
    channel_combine_resampler dut (.clk_in, .reset_n_in, .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .hrdata_out(hrdata), .ch_i_in(ci), .ch_q_in(cq), .ch_valid_in(cv), .ch_ready_out(cr),
        .coef_addr_out(coef_addr), .coef_in(coef), .res_i_out(res_i), .res_q_out(res_q),
        .res_chan_out(res_chan), .res_valid_out(res_valid), .res_ready_in(res_ready));
    upstream_channels src (.clk_in, .reset_n_in, .en_in(en), .slow_in(slow),
        .lane_i_in(lane_i), .lane_q_in(lane_q), .ch_ready_in(cr), .ch_i_out(ci),
        .ch_q_out(cq), .ch_valid_out(cv));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk_in);
        fails++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd_chk(32'h40, 32'h2);
        rd_chk(32'h44, 32'h207);
        rd_chk(32'h140, 32'h04000000);
        rd_chk(32'h1000, 32'h0);
        bus(1'b1, 32'h150, 32'h08000000);
        rd_chk(32'h150, 32'h08000000);
        bus(1'b1, 32'h5C, 32'hE4);
        rd_chk(32'h5C, 32'hE4);
        $display("test registers done");
        for (int k = 0; k < 4; k++) bus(1'b1, 32'h80 + 32'(4 * k),
            (k == 1) ? 32'h4000 : (k == 3) ? 32'hC000 : 32'h0);
        bus(1'b1, 32'h54, 32'h0000E501);
        for (int k = 0; k < 4; k++) begin
            ei[k] = (k == 1) ? 44'(li[0]) - 44'(lq[1]) : (k == 3) ? 44'(lq[3]) : 44'(li[k]);
            eq[k] = (k == 1) ? 44'(lq[0]) + 44'(li[1]) : (k == 3) ? -44'(li[3]) : 44'(lq[k]);
            ei[k] = 44'sd7 * ei[k];
            eq[k] = 44'sd7 * eq[k];
        end
        en <= 1'b1;
        n = 0;
        // output held back, so the segments must fill and refuse frames
        do @(posedge clk_in); while (cr !== 1'b0 && ++n < 300);
        `CHK(cr, 1'b0)
        rd_chk(32'hA0, 32'h10101000);
        `CHK(res_valid, 1'b1)
        slow <= 1'b1;
        res_ready <= 1'b1;
        n = 0;
        while (n < 12) begin
            @(posedge clk_in);
            if (res_valid === 1'b1) begin
                n++;
                `CHK(res_chan != 2'h0, 1'b1)
                `CHK(res_i, ei[res_chan])
                `CHK(res_q, eq[res_chan])
            end
        end
        $display("test stream done");
        test_done();
    end
endmodule
